// ===== core/byte_alu_pkg.sv
// Constants and types for the serial-controlled byte arithmetic unit
package byte_alu_pkg;
	localparam int CLK_HZ_DEFAULT = 50000000;
	localparam int BAUD_DEFAULT = 115200;
	localparam int DATA_BITS = 8;
	localparam int SYNC_STAGES = 3;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_ADD = 8'h01;
	localparam logic [7:0] OP_SUB = 8'h02;
	localparam logic [7:0] OP_AND = 8'h03;
	localparam logic [7:0] OP_OR = 8'h04;
	localparam logic [7:0] OP_XOR = 8'h05;
	localparam logic [7:0] OP_SHL = 8'h06;
	localparam logic [7:0] OP_SHR = 8'h07;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] UIO_OE_VALUE = 8'h02;
	localparam int RX_PIN = 0;
	localparam int TX_PIN = 1;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] op_a;
		logic [7:0] op_b;
	} command_t;

	typedef enum logic [1:0] {
		CMD_OPCODE,
		CMD_A,
		CMD_B,
		CMD_REPLY
	} cmd_state_t;

	typedef enum logic [1:0] {
		LINE_IDLE,
		LINE_START,
		LINE_DATA,
		LINE_STOP
	} line_state_t;
endpackage

// ===== core/byte_alu_uart.sv
// Serial-controlled 8-bit arithmetic unit with 8N1 receiver and transmitter
`timescale 1ns/1ps
// Summary of operation
// - Frames are idle high, start low, eight data bits LSB first, one stop.
// - Default parameters give 115200 baud from a 50 MHz clock.
// - A command is three bytes: opcode 0x00..0x07, operand A, operand B.
// - After the third byte, one result byte is transmitted.
// - Code 0 gives zero, 1 gives A+B, 2 gives A-B, truncated to eight bits.
// - Codes 3, 4, 5 give bitwise AND, OR, XOR of A and B.
// - Code 6 shifts A left by B[2:0], zero filled.
// - Code 7 shifts A right logically by B[2:0], zero filled.
// - Receive on bidirectional bit 0, transmit on bit 1 enabled as output.
// - Clock rate and baud are overridable parameters.
module byte_alu_uart #(
	parameter int CLK_HZ = byte_alu_pkg::CLK_HZ_DEFAULT,
	parameter int BAUD = byte_alu_pkg::BAUD_DEFAULT
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_uio_in,
	output logic [7:0] o_uio_out,
	output logic [7:0] o_uio_oe
);
	import byte_alu_pkg::*;

	// Clocks per bit, at least one
	localparam int BIT_CYC = (CLK_HZ / BAUD) < 1 ? 1 : (CLK_HZ / BAUD);
	localparam int HALF_CYC = (BIT_CYC / 2) < 1 ? 1 : (BIT_CYC / 2);
	localparam int CW = $clog2(BIT_CYC + 1);
	localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);
	localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

	// Input synchroniser on the receive pin
	logic [SYNC_STAGES-1:0] sync_reg;
	logic rx_level_reg;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
			sync_reg <= '1;
		else
			sync_reg <= {sync_reg[SYNC_STAGES-2:0], i_uio_in[RX_PIN]};
	end
	wire sync_agree = (sync_reg[1] == sync_reg[2]);
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
			rx_level_reg <= 1'b1;
		else if (sync_agree)
			rx_level_reg <= sync_reg[2];
	end

	// Receiver
	line_state_t rx_state_reg, rx_state_next;
	logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
	logic [2:0] rx_bit_reg, rx_bit_next;
	logic [7:0] rx_shift_reg, rx_shift_next;
	logic rx_done_reg, rx_done_next;

	wire rx_tick = (rx_cnt_reg == '0);
	always_comb
	begin
		rx_state_next = rx_state_reg;
		rx_cnt_next = rx_tick ? rx_cnt_reg : rx_cnt_reg - 1'b1;
		rx_bit_next = rx_bit_reg;
		rx_shift_next = rx_shift_reg;
		rx_done_next = 1'b0;
		case (rx_state_reg)
			LINE_IDLE:
				if (!rx_level_reg)
				begin
					rx_state_next = LINE_START;
					rx_cnt_next = HALF_LAST;
				end
			LINE_START:
				if (rx_tick)
				begin
					// Mid start bit: reject glitches
					rx_state_next = rx_level_reg ? LINE_IDLE : LINE_DATA;
					rx_cnt_next = BIT_LAST;
					rx_bit_next = '0;
				end
			LINE_DATA:
				if (rx_tick)
				begin
					rx_shift_next = {rx_level_reg, rx_shift_reg[7:1]};
					rx_cnt_next = BIT_LAST;
					rx_bit_next = rx_bit_reg + 1'b1;
					if (rx_bit_reg == LAST_BIT)
						rx_state_next = LINE_STOP;
				end
			LINE_STOP:
				if (rx_tick)
				begin
					// Framing error drops the byte
					rx_done_next = rx_level_reg;
					rx_state_next = LINE_IDLE;
				end
			default:
				rx_state_next = LINE_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			rx_state_reg <= LINE_IDLE;
			rx_cnt_reg <= '0;
			rx_bit_reg <= '0;
			rx_shift_reg <= BYTE_RESET;
			rx_done_reg <= 1'b0;
		end
		else
		begin
			rx_state_reg <= rx_state_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bit_reg <= rx_bit_next;
			rx_shift_reg <= rx_shift_next;
			rx_done_reg <= rx_done_next;
		end
	end

	// Command sequencer and arithmetic
	cmd_state_t cmd_state_reg, cmd_state_next;
	command_t cmd_reg, cmd_next;
	logic tx_start;
	logic tx_busy;
	logic [7:0] alu_result;

	always_comb
	begin
		case (cmd_reg.opcode)
			OP_ADD: alu_result = 8'(cmd_reg.op_a + cmd_reg.op_b);
			OP_SUB: alu_result = 8'(cmd_reg.op_a - cmd_reg.op_b);
			OP_AND: alu_result = cmd_reg.op_a & cmd_reg.op_b;
			OP_OR: alu_result = cmd_reg.op_a | cmd_reg.op_b;
			OP_XOR: alu_result = cmd_reg.op_a ^ cmd_reg.op_b;
			OP_SHL: alu_result = cmd_reg.op_a << cmd_reg.op_b[2:0];
			OP_SHR: alu_result = cmd_reg.op_a >> cmd_reg.op_b[2:0];
			default: alu_result = BYTE_RESET;
		endcase
	end

	always_comb
	begin
		cmd_state_next = cmd_state_reg;
		cmd_next = cmd_reg;
		tx_start = 1'b0;
		case (cmd_state_reg)
			CMD_OPCODE:
				if (rx_done_reg)
				begin
					cmd_next.opcode = rx_shift_reg;
					cmd_state_next = CMD_A;
				end
			CMD_A:
				if (rx_done_reg)
				begin
					cmd_next.op_a = rx_shift_reg;
					cmd_state_next = CMD_B;
				end
			CMD_B:
				if (rx_done_reg)
				begin
					cmd_next.op_b = rx_shift_reg;
					cmd_state_next = CMD_REPLY;
				end
			CMD_REPLY:
				if (!tx_busy)
				begin
					tx_start = 1'b1;
					cmd_state_next = CMD_OPCODE;
				end
			default:
				cmd_state_next = CMD_OPCODE;
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			cmd_state_reg <= CMD_OPCODE;
			cmd_reg <= '0;
		end
		else
		begin
			cmd_state_reg <= cmd_state_next;
			cmd_reg <= cmd_next;
		end
	end

	// Transmitter
	line_state_t tx_state_reg, tx_state_next;
	logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
	logic [2:0] tx_bit_reg, tx_bit_next;
	logic [7:0] tx_shift_reg, tx_shift_next;
	logic tx_line_reg, tx_line_next;

	wire tx_tick = (tx_cnt_reg == '0);
	assign tx_busy = (tx_state_reg != LINE_IDLE);

	always_comb
	begin
		tx_state_next = tx_state_reg;
		tx_cnt_next = tx_tick ? tx_cnt_reg : tx_cnt_reg - 1'b1;
		tx_bit_next = tx_bit_reg;
		tx_shift_next = tx_shift_reg;
		tx_line_next = tx_line_reg;
		case (tx_state_reg)
			LINE_IDLE:
			begin
				tx_line_next = 1'b1;
				if (tx_start)
				begin
					tx_shift_next = alu_result;
					tx_line_next = 1'b0;
					tx_cnt_next = BIT_LAST;
					tx_state_next = LINE_START;
				end
			end
			LINE_START:
				if (tx_tick)
				begin
					tx_line_next = tx_shift_reg[0];
					tx_shift_next = {1'b0, tx_shift_reg[7:1]};
					tx_bit_next = '0;
					tx_cnt_next = BIT_LAST;
					tx_state_next = LINE_DATA;
				end
			LINE_DATA:
				if (tx_tick)
				begin
					tx_cnt_next = BIT_LAST;
					tx_bit_next = tx_bit_reg + 1'b1;
					if (tx_bit_reg == LAST_BIT)
					begin
						tx_line_next = 1'b1;
						tx_state_next = LINE_STOP;
					end
					else
					begin
						tx_line_next = tx_shift_reg[0];
						tx_shift_next = {1'b0, tx_shift_reg[7:1]};
					end
				end
			LINE_STOP:
				if (tx_tick)
					tx_state_next = LINE_IDLE;
			default:
				tx_state_next = LINE_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			tx_state_reg <= LINE_IDLE;
			tx_cnt_reg <= '0;
			tx_bit_reg <= '0;
			tx_shift_reg <= BYTE_RESET;
			tx_line_reg <= 1'b1;
			o_uio_out <= BYTE_RESET;
			o_uio_oe <= BYTE_RESET;
		end
		else
		begin
			tx_state_reg <= tx_state_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_bit_reg <= tx_bit_next;
			tx_shift_reg <= tx_shift_next;
			tx_line_reg <= tx_line_next;
			o_uio_out <= {6'h00, tx_line_next, 1'b0};
			o_uio_oe <= UIO_OE_VALUE;
		end
	end

	// Checks
	a_reply_once: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(cmd_state_reg == CMD_B && rx_done_reg) |=> ##[1:3] (tx_state_reg == LINE_START))
		else $error("result byte not started after third byte");
	a_start_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(tx_state_reg == LINE_START) |-> (o_uio_out[TX_PIN] == 1'b0))
		else $error("start bit not low");
	a_stop_high: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(tx_state_reg == LINE_STOP) |-> (o_uio_out[TX_PIN] == 1'b1))
		else $error("stop bit not high");
	a_idle_high: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		($past(i_nrst) && tx_state_reg == LINE_IDLE && $past(tx_state_reg) == LINE_IDLE)
		|-> o_uio_out[TX_PIN])
		else $error("idle line not high");
	a_tx_enabled: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		$past(i_nrst) |-> (o_uio_oe == UIO_OE_VALUE))
		else $error("transmit pin not enabled");
	a_add_result: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(tx_start && cmd_reg.opcode == OP_ADD) |=>
		(tx_shift_reg == 8'(cmd_reg.op_a + cmd_reg.op_b)))
		else $error("add result wrong");
	a_shr_result: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(tx_start && cmd_reg.opcode == OP_SHR) |=>
		(tx_shift_reg == ($past(cmd_reg.op_a) >> $past(cmd_reg.op_b[2:0]))))
		else $error("shift right result wrong");
	a_bad_opcode: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(tx_start && cmd_reg.opcode > OP_SHR) |=> (tx_shift_reg == BYTE_RESET))
		else $error("undefined opcode not zero");
	a_back_to_op: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		tx_start |=> (cmd_state_reg == CMD_OPCODE))
		else $error("not back to opcode wait");
	a_bit_time: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(tx_state_reg == LINE_START && $past(tx_state_reg) == LINE_IDLE) |-> (tx_cnt_reg == BIT_LAST))
		else $error("bit time wrong");

	c_byte_rx: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) rx_done_reg);
	c_reply: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) tx_start);
	c_sub: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
		tx_start && cmd_reg.opcode == OP_SUB);
	c_tx_done: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
		tx_state_reg == LINE_STOP ##1 tx_state_reg == LINE_IDLE);
endmodule

// ===== testbench/host_serial_model.sv
// Host serial port model: 8N1 sender and free-running receiver
`timescale 1ns/1ps
module host_serial_model #(
	parameter int BIT = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_tx,
	output logic o_rx
);
	// Received bytes, top bit set when framing was good
	logic [8:0] rx_q[$];
	logic [7:0] data;
	logic ok;

	initial o_rx = 1'b1;

	// Start low, eight data bits LSB first, stop high, idle high
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		@(posedge i_sys_clk);
		#1;
		for (int i = 0; i < 10; i++)
		begin
			o_rx = frame[i];
			repeat (BIT) @(posedge i_sys_clk);
			#1;
		end
	endtask

	// Samples each bit of the reply at its middle
	always
	begin
		@(posedge i_sys_clk);
		#2;
		if (i_nrst === 1'b1 && i_tx === 1'b0)
		begin
			repeat (BIT / 2 - 1) @(posedge i_sys_clk);
			#2;
			ok = (i_tx === 1'b0);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge i_sys_clk);
				#2;
				data[i] = i_tx;
			end
			repeat (BIT) @(posedge i_sys_clk);
			#2;
			ok = ok & (i_tx === 1'b1);
			rx_q.push_back({ok, data});
		end
	end
endmodule

// ===== testbench/uart_driven_byte_alu_test.sv
// Self-checking bench for the serial byte arithmetic unit
`timescale 1ns/1ps
module uart_driven_byte_alu_test;
	import byte_alu_pkg::*;
	localparam int BIT = 16;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic rx;
	logic [7:0] uio_in;
	logic [7:0] uio_out;
	logic [7:0] uio_oe;
	int num_errors = 0;
	int comparisons = 0;

	always #12.5 clk = ~clk;
	// Unused pin inputs carry a pattern the unit must ignore
	assign uio_in = {7'h55, rx};
	// Pull-up holds the line high while the pin is released
	wire tx_line = uio_oe[TX_PIN] ? uio_out[TX_PIN] : 1'b1;

	byte_alu_uart #(.CLK_HZ(76800), .BAUD(4800)) u_byte_alu_uart (
		.i_sys_clk(clk),
		.i_nrst(nrst),
		.i_uio_in(uio_in),
		.o_uio_out(uio_out),
		.o_uio_oe(uio_oe)
	);

	host_serial_model #(.BIT(BIT)) u_host_serial_model (
		.i_sys_clk(clk),
		.i_nrst(nrst),
		.i_tx(tx_line),
		.o_rx(rx)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [7:0] alu_ref(input logic [7:0] op, a, b);
		case (op)
			OP_ADD: return a + b;
			OP_SUB: return a - b;
			OP_AND: return a & b;
			OP_OR: return a | b;
			OP_XOR: return a ^ b;
			OP_SHL: return a << b[2:0];
			OP_SHR: return a >> b[2:0];
			default: return 8'h00;
		endcase
	endfunction

	// Waits for one reply, then checks that no second byte follows
	task automatic expect_reply(input logic [7:0] exp);
		int n;
		logic [8:0] got;
		n = 0;
		while (u_host_serial_model.rx_q.size() == 0 && n < 20 * BIT)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20 * BIT)
		begin
			num_errors++;
			conclude();
		end
		else
		begin
			got = u_host_serial_model.rx_q.pop_front();
			check({7'h00, got[8]}, 8'h01);
			check(got[7:0], exp);
			repeat (12 * BIT) @(posedge clk);
			check(8'(u_host_serial_model.rx_q.size()), 8'h00);
		end
	endtask

	task automatic run_cmd(input logic [7:0] op, a, b);
		u_host_serial_model.send_byte(op);
		u_host_serial_model.send_byte(a);
		u_host_serial_model.send_byte(b);
		expect_reply(alu_ref(op, a, b));
	endtask

	task automatic test_reset;
		repeat (2) @(posedge clk);
		#1;
		check(uio_oe, 8'h00);
		check(uio_out, 8'h00);
		repeat (18) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(uio_oe, UIO_OE_VALUE);
		check(uio_out, 8'h02);
	endtask

	task automatic test_all_ops;
		for (int op = 0; op < 8; op++)
			run_cmd(8'(op), 8'hB7, 8'h5D);
		run_cmd(OP_SUB, 8'h14, 8'h1E);
		run_cmd(OP_SHL, 8'h81, 8'hF8);
		run_cmd(OP_SHR, 8'hF0, 8'h0F);
		run_cmd(OP_ADD, 8'h14, 8'h1E);
	endtask

	task automatic test_undefined;
		run_cmd(8'h08, 8'hFF, 8'h01);
		run_cmd(8'hFF, 8'h3C, 8'hC3);
	endtask

	task automatic test_reset_mid;
		u_host_serial_model.send_byte(OP_XOR);
		u_host_serial_model.send_byte(8'hAA);
		@(posedge clk);
		#1;
		nrst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'b1;
		run_cmd(OP_OR, 8'h12, 8'h48);
		run_cmd(OP_AND, 8'hF3, 8'h3E);
	endtask

	initial
	begin
		test_reset();
		test_all_ops();
		test_undefined();
		test_reset_mid();
		conclude();
	end
endmodule
